// File: include/frt_defines.svh
// Register offsets, field positions, reset values and constants of the timer
`ifndef FRT_DEFINES_SVH
`define FRT_DEFINES_SVH
`define FRT_ADDR_W       4
`define FRT_DATA_W       16
`define FRT_OFF_CTL0     4'h0
`define FRT_OFF_CTL1     4'h1
`define FRT_OFF_OPT      4'h2
`define FRT_OFF_EDGE     4'h3
`define FRT_OFF_CNT      4'h4
`define FRT_OFF_STAT     4'h5
`define FRT_OFF_MASK     4'h6
`define FRT_OFF_CCR0     4'h8
`define FRT_OFF_CCR1     4'h9
`define FRT_OFF_CCR2     4'ha
`define FRT_CTL0_RUN     7
`define FRT_CTL0_CKS_LO  0
`define FRT_CTL1_MODE_LO 0
`define FRT_OPT_OVF      0
`define FRT_OPT_CCS_LO   4
`define FRT_STAT_OVF     0
`define FRT_STAT_CH_LO   1
`define FRT_MODE_FREE    3'b101
`define FRT_CNT_IDLE     16'hffff
`define FRT_CNT_TOP      16'hffff
`define FRT_RST_CTL0     8'h00
`define FRT_RST_CTL1     8'h00
`define FRT_RST_OPT      8'h00
`define FRT_RST_EDGE     8'h00
`define FRT_RST_MASK     5'h00
`define FRT_RST_CCR      16'h0000
`define FRT_PRESC_W      7
`endif

// File: include/frt_pkg.sv
// Types shared by the free-running capture/compare timer
package frt_pkg;
  // One register bus request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } frt_bus_req_type;

  // Counter sequencing, Gray coded along idle -> armed -> run
  typedef enum logic [1:0] {
    FRT_IDLE  = 2'b00,
    FRT_ARMED = 2'b01,
    FRT_RUN   = 2'b11
  } frt_state_type;

  // Edge selection per capture input
  typedef enum logic [1:0] {
    FRT_EDGE_NONE = 2'b00,
    FRT_EDGE_RISE = 2'b01,
    FRT_EDGE_FALL = 2'b10,
    FRT_EDGE_BOTH = 2'b11
  } frt_edge_type;
endpackage

// File: rtl/frt_timer.sv
// Free-running 16-bit timer with four capture/compare channels and register port
//
// Contract
// - Free-running operation only while the mode field holds 101.
// - Compare works on every unit; capture only where CAPTURE_EN is set.
// - Counter increments once the run bit is 1.
// - Each channel's capture-select bit picks capture or compare.
// - Compare pins of channels in compare mode invert when counting starts; pins of capture channels hold.
// - Counter equal to compare register: channel interrupt and pin inversion.
// - Counter never cleared by match or capture.
// - Count clock after FFFFH: overflow interrupt, wrap to 0000H, keep counting.
// - Sticky overflow flag set at each wrap until software clears it.
// - Compare register writes take effect immediately, no buffering.
// - Valid capture edge latches counter and raises the channel interrupt.
// - Overflow flag at option bit 0; cleared by writing 0 there.
// - Capture right after start may read FFFFH instead of 0000H.
// - On enable the counter goes from idle FFFFH to 0000H, then counts up.
`timescale 1ns/10ps
`include "frt_defines.svh"

module frt_timer #(
  parameter int       NUM_CH     = 4,
  parameter bit       CAPTURE_EN = 1'b1
) (
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     ce,
  input  wire frt_pkg::frt_bus_req_type bus_req,
  output logic [15:0]                   rdata,
  input  wire logic [NUM_CH-1:0]        capture_in_pin,
  output logic [NUM_CH-1:0]             compare_out_pin,
  output logic                          counter_wrap_irq,
  output logic [NUM_CH-1:0]             match_or_capture_irq,
  output logic                          irq
);
  import frt_pkg::*;

  // Option and edge registers are eight bits wide, so four channels at most
  if (NUM_CH < 1 || NUM_CH > 4) begin : g_check
    $error("frt_timer: NUM_CH must be 1 to 4");
  end

  localparam int SW = NUM_CH + 1;

  logic [7:0]               ctl0_reg;
  logic [7:0]               ctl1_reg;
  logic [NUM_CH-1:0]        ccs_reg;
  logic                     ovf_reg;
  logic [7:0]               edge_reg;
  logic [SW-1:0]            stat_reg;
  logic [SW-1:0]            mask_reg;
  logic [15:0]              ccr_reg [NUM_CH];
  logic [15:0]              cnt_reg;
  logic [`FRT_PRESC_W-1:0]  presc_reg;
  frt_state_type            state_reg;
  logic [NUM_CH-1:0]        sync1_reg;
  logic [NUM_CH-1:0]        sync2_reg;
  logic [NUM_CH-1:0]        prev_reg;

  logic                     active;
  logic                     tick;
  logic                     wrap_evt;
  logic                     start_evt;
  logic [NUM_CH-1:0]        ccs_eff;
  logic [NUM_CH-1:0]        match_evt;
  logic [NUM_CH-1:0]        cap_evt;
  logic [NUM_CH-1:0]        edge_evt;
  logic [NUM_CH-1:0]        ccr_wr;
  logic [`FRT_PRESC_W-1:0]  presc_limit;

  // Register write decode, shared by every writable register
  function automatic logic wr_hit(input frt_bus_req_type r, input logic [3:0] off);
    wr_hit = r.wr && (r.addr == off);
  endfunction

  // Prescaler terminal count for divide by 2^sel
  function automatic logic [`FRT_PRESC_W-1:0] limit_of(input logic [2:0] sel);
    limit_of = `FRT_PRESC_W'((1 << sel) - 1);
  endfunction

  // Run only in free-running mode with the run bit set
  assign active    = ctl0_reg[`FRT_CTL0_RUN] &&
                     (ctl1_reg[`FRT_CTL1_MODE_LO +: 3] == `FRT_MODE_FREE);
  assign presc_limit = limit_of(ctl0_reg[`FRT_CTL0_CKS_LO +: 3]);
  assign tick      = (state_reg != FRT_IDLE) && (presc_reg == presc_limit);
  assign start_evt = active && (state_reg == FRT_IDLE);
  // The first tick after start only leaves the idle value, so it is no wrap
  assign wrap_evt  = tick && (state_reg == FRT_RUN) && (cnt_reg == `FRT_CNT_TOP);
  // A unit without capture hardware treats every channel as compare
  assign ccs_eff   = ccs_reg & {NUM_CH{CAPTURE_EN}};

  // Per channel match, edge and capture decode
  for (genvar a = 0; a < NUM_CH; a++) begin : g_ch
    logic [1:0] esel;
    assign esel = edge_reg[2*a +: 2];
    assign ccr_wr[a] = wr_hit(bus_req, `FRT_OFF_CCR0 + 4'(a));
    // Match seen at the count-up after equality; compare reads live value
    assign match_evt[a] = tick && (state_reg == FRT_RUN) && !ccs_eff[a] &&
                          (cnt_reg == ccr_reg[a]);
    always_comb begin
      case (esel)
        FRT_EDGE_RISE: edge_evt[a] = sync2_reg[a] && !prev_reg[a];
        FRT_EDGE_FALL: edge_evt[a] = !sync2_reg[a] && prev_reg[a];
        FRT_EDGE_BOTH: edge_evt[a] = sync2_reg[a] ^ prev_reg[a];
        default:       edge_evt[a] = 1'b0;
      endcase
    end
    assign cap_evt[a] = active && ccs_eff[a] && edge_evt[a];
  end

  // Capture input synchronisers; first stage feeds only the second
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else if (ce) begin
      sync1_reg <= capture_in_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Counter sequencing
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= FRT_IDLE;
    end else if (ce) begin
      if (!active) begin
        state_reg <= FRT_IDLE;
      end else begin
        case (state_reg)
          FRT_IDLE:  state_reg <= FRT_ARMED;
          FRT_ARMED: state_reg <= tick ? FRT_RUN : FRT_ARMED;
          FRT_RUN:   state_reg <= FRT_RUN;
          default:   state_reg <= FRT_IDLE;
        endcase
      end
    end
  end

  // Count clock prescaler, restarted at every start
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      presc_reg <= '0;
    end else if (ce) begin
      if (state_reg == FRT_IDLE || tick) begin
        presc_reg <= '0;
      end else begin
        presc_reg <= presc_reg + 1'b1;
      end
    end
  end

  // Counter: idles at FFFFH, first tick gives 0000H, wraps freely
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= `FRT_CNT_IDLE;
    end else if (ce) begin
      if (!active) begin
        cnt_reg <= `FRT_CNT_IDLE;
      end else if (tick) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl0_reg <= `FRT_RST_CTL0;
      ctl1_reg <= `FRT_RST_CTL1;
      edge_reg <= `FRT_RST_EDGE;
      mask_reg <= SW'(`FRT_RST_MASK);
    end else if (ce) begin
      if (wr_hit(bus_req, `FRT_OFF_CTL0)) begin
        ctl0_reg <= bus_req.wdata[7:0];
      end
      if (wr_hit(bus_req, `FRT_OFF_CTL1)) begin
        ctl1_reg <= bus_req.wdata[7:0];
      end
      if (wr_hit(bus_req, `FRT_OFF_EDGE)) begin
        edge_reg <= bus_req.wdata[7:0];
      end
      if (wr_hit(bus_req, `FRT_OFF_MASK)) begin
        mask_reg <= bus_req.wdata[SW-1:0];
      end
    end
  end

  // Option register: select bits and sticky overflow flag, set beats clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ccs_reg <= NUM_CH'(`FRT_RST_OPT >> `FRT_OPT_CCS_LO);
      ovf_reg <= 1'b0;
    end else if (ce) begin
      if (wr_hit(bus_req, `FRT_OFF_OPT)) begin
        ccs_reg <= bus_req.wdata[`FRT_OPT_CCS_LO +: NUM_CH];
      end
      if (wrap_evt) begin
        ovf_reg <= 1'b1;
      end else if (wr_hit(bus_req, `FRT_OFF_OPT) && !bus_req.wdata[`FRT_OPT_OVF]) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // Capture/compare registers; a capture wins over a same-cycle write
  for (genvar a = 0; a < NUM_CH; a++) begin : g_ccr
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        ccr_reg[a] <= `FRT_RST_CCR;
      end else if (ce) begin
        if (cap_evt[a]) begin
          ccr_reg[a] <= cnt_reg;
        end else if (ccr_wr[a]) begin
          ccr_reg[a] <= bus_req.wdata;
        end
      end
    end
  end

  // Compare pins of compare-mode channels toggle at start and on each match
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      compare_out_pin <= '0;
    end else if (ce) begin
      compare_out_pin <= compare_out_pin ^
                         (match_evt | ({NUM_CH{start_evt}} & ~ccs_eff));
    end
  end

  // Event pulses, sticky status with write-one-clear, masked interrupt
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      counter_wrap_irq     <= 1'b0;
      match_or_capture_irq <= '0;
      stat_reg             <= '0;
      irq                  <= 1'b0;
    end else if (ce) begin
      counter_wrap_irq     <= wrap_evt;
      match_or_capture_irq <= match_evt | cap_evt;
      // Clear first, then OR events in, so a new event is never lost
      stat_reg <= (stat_reg & ~({SW{wr_hit(bus_req, `FRT_OFF_STAT)}} & bus_req.wdata[SW-1:0]))
                  | {match_evt | cap_evt, wrap_evt};
      irq      <= |(stat_reg & mask_reg);
    end
  end

  // Read port, data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= 16'h0000;
      if (bus_req.rd) begin
        case (bus_req.addr)
          `FRT_OFF_CTL0: rdata <= {8'h00, ctl0_reg};
          `FRT_OFF_CTL1: rdata <= {8'h00, ctl1_reg};
          `FRT_OFF_OPT:  rdata <= 16'(({4'h0, 4'(ccs_reg)} << `FRT_OPT_CCS_LO) | 8'(ovf_reg));
          `FRT_OFF_EDGE: rdata <= {8'h00, edge_reg};
          `FRT_OFF_CNT:  rdata <= cnt_reg;
          `FRT_OFF_STAT: rdata <= 16'(stat_reg);
          `FRT_OFF_MASK: rdata <= 16'(mask_reg);
          default: begin
            for (int a = 0; a < NUM_CH; a++) begin
              if (bus_req.addr == `FRT_OFF_CCR0 + 4'(a)) begin
                rdata <= ccr_reg[a];
              end
            end
          end
        endcase
      end
    end
  end

endmodule // frt_timer

// File: tb/frt_timer_props.sv
// Port-level checks for the free-running capture/compare timer
`timescale 1ns/10ps
`include "frt_defines.svh"
module frt_timer_props #(
  parameter int NUM_CH = 4
) (
  input wire logic                     mclk,
  input wire logic                     rstn,
  input wire logic                     ce,
  input wire frt_pkg::frt_bus_req_type bus_req,
  input wire logic [15:0]              rdata,
  input wire logic [NUM_CH-1:0]        capture_in_pin,
  input wire logic [NUM_CH-1:0]        compare_out_pin,
  input wire logic                     counter_wrap_irq,
  input wire logic [NUM_CH-1:0]        match_or_capture_irq,
  input wire logic                     irq
);
  import frt_pkg::*;
  logic        ovf_seen;
  logic [16:0] gap;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Expected overflow flag; a clearing write beats a wrap seen in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      ovf_seen <= 1'b0;
    else if (ce && bus_req.wr && bus_req.addr == `FRT_OFF_OPT && !bus_req.wdata[0])
      ovf_seen <= 1'b0;
    else if (counter_wrap_irq)
      ovf_seen <= 1'b1;
  end
  // Cycles since the last wrap pulse, saturating
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      gap <= 17'h00000;
    else
      gap <= counter_wrap_irq ? 17'h00000 : gap + {16'h0000, ~&gap};
  end
  a_wrap_single: assert property (counter_wrap_irq |=> !counter_wrap_irq)
    else $error("wrap pulse longer than one cycle");
  a_wrap_spacing: assert property (counter_wrap_irq |-> gap >= 17'h0ffff)
    else $error("wraps closer than a full count");
  a_ovf_read: assert property (
    bus_req.rd && bus_req.addr == `FRT_OFF_OPT |=> rdata[0] == $past(ovf_seen || counter_wrap_irq))
    else $error("overflow flag read wrong");
  a_cnt_step: assert property (
    (bus_req.rd && bus_req.addr == `FRT_OFF_CNT) ##2 (bus_req.rd && bus_req.addr == `FRT_OFF_CNT)
    |=> 16'(rdata - $past(rdata, 2)) <= 16'h0002)
    else $error("counter jumped between reads");
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_irq_cause: assert property ($rose(irq) |-> $past(bus_req.wr, 2)
    || $past(counter_wrap_irq || |match_or_capture_irq)
    || $past(counter_wrap_irq || |match_or_capture_irq, 2))
    else $error("interrupt raised without cause");
  a_irq_drop: assert property ($fell(irq) |-> $past(bus_req.wr, 2))
    else $error("interrupt dropped without a write");
  a_pin_cause: assert property ($changed(compare_out_pin) |->
    $past(bus_req.wr) || $past(bus_req.wr, 2)
    || ((compare_out_pin ^ $past(compare_out_pin)) & ~match_or_capture_irq) == '0)
    else $error("compare pin moved without a match");
  c_wrap: cover property (counter_wrap_irq);
  c_match: cover property (match_or_capture_irq[0]);
  c_irq: cover property ($rose(irq));
endmodule // frt_timer_props

bind frt_timer frt_timer_props #(.NUM_CH(NUM_CH)) u_props (.mclk(mclk), .rstn(rstn), .ce(ce),
  .bus_req(bus_req), .rdata(rdata), .capture_in_pin(capture_in_pin),
  .compare_out_pin(compare_out_pin), .counter_wrap_irq(counter_wrap_irq),
  .match_or_capture_irq(match_or_capture_irq), .irq(irq));

// File: tb/frt_pins_model.sv
// Far-side pin model: drives the capture inputs
`timescale 1ns/10ps
module frt_pins_model (
  input  wire logic       mclk,
  output logic      [3:0] capture_in_pin
);
  import frt_pkg::*;
  initial capture_in_pin = 4'h0;
  // Invert chosen inputs just after an edge, held until the next call
  task automatic flip(input logic [3:0] sel);
    @(posedge mclk);
    capture_in_pin <= capture_in_pin ^ sel;
  endtask
endmodule // frt_pins_model

// File: tb/tb_top.sv
// Self-checking bench for the free-running capture/compare timer
`timescale 1ns/10ps
`include "frt_defines.svh"
module tb_top;
  import frt_pkg::*;
  logic            mclk, rstn, ce, wrap, irq;
  frt_bus_req_type req;
  logic [15:0]     rdata, v, c;
  logic [3:0]      cap, pin, pin1, mci, mci1, p, q;
  int              mismatches, n_tests;
  logic [15:0]     c2;
  int              nw;
  time             t0, t1;

  frt_timer dut (.mclk(mclk), .rstn(rstn), .ce(ce), .bus_req(req), .rdata(rdata),
    .capture_in_pin(cap), .compare_out_pin(pin), .counter_wrap_irq(wrap),
    .match_or_capture_irq(mci), .irq(irq));
  // Second unit without capture, sharing bus and capture pins
  frt_timer #(.CAPTURE_EN(1'b0)) dut_unit1 (.mclk(mclk), .rstn(rstn), .ce(ce),
    .bus_req(req), .rdata(), .capture_in_pin(cap), .compare_out_pin(pin1),
    .counter_wrap_irq(), .match_or_capture_irq(mci1), .irq());
  frt_pins_model u_pins (.mclk(mclk), .capture_in_pin(cap));

  // Bus cycles and comparisons
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Bounded wait for a channel pulse (0..3) or the wrap pulse (4)
  task wt(input int b, input int lim, input string m);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge mclk);
      #1;
      if ((b < 4) ? mci[b] : wrap) break;
    end
    chk(i < lim, 1, m);
  endtask

  task t_compare;
    rd(`FRT_OFF_CNT); chk(v, `FRT_CNT_IDLE, "idle count");
    wr(`FRT_OFF_CCR0, 16'h0007);
    wr(`FRT_OFF_CTL0, 16'h0080);
    rd(`FRT_OFF_CNT); chk(v, `FRT_CNT_IDLE, "counted outside mode");
    p = ~pin;
    wr(`FRT_OFF_CTL1, 16'h0005);
    // Two edges only: channels left at zero match on the tick after that
    repeat (2) @(posedge mclk);
    #1 chk(pin, p, "start toggle");
    wt(0, 20, "match pulse");
    chk(pin[0] ^ p[0], 1, "match toggle");
    rd(`FRT_OFF_CNT); chk(v > 16'h0007 && v < 16'h0010, 1, "kept counting");
    wr(`FRT_OFF_CCR0, 16'h000f);
    wt(0, 12, "new compare value used");
    rd(`FRT_OFF_STAT); chk(v[1], 1, "channel status");
    chk(irq, 0, "masked interrupt");
    wr(`FRT_OFF_MASK, 16'h0002);
    @(posedge mclk);
    #1 chk(irq, 1, "unmasked interrupt");
    wr(`FRT_OFF_STAT, 16'h0002);
    @(posedge mclk);
    #1 chk(irq, 0, "interrupt cleared");
  endtask

  task t_capture;
    wr(`FRT_OFF_CTL0, 16'h0000);
    wr(`FRT_OFF_OPT, 16'h0060);
    wr(`FRT_OFF_EDGE, 16'h0004);
    p = pin;
    q = ~pin1;
    wr(`FRT_OFF_CTL0, 16'h0080);
    repeat (2) @(posedge mclk);
    #1 chk(pin[2:1] ^ p[2:1], 0, "capture pins held");
    chk(pin1, q, "unit without capture toggles all");
    u_pins.flip(4'h6);
    wt(1, 10, "capture pulse");
    chk({mci[2], mci1[1]}, 0, "unselected edge or no capture unit");
    rd(`FRT_OFF_CCR1); c = v;
    rd(`FRT_OFF_CNT); chk(v - c < 16'h0010, 1, "captured count");
    rd(`FRT_OFF_CCR2); chk(v, 16'h0000, "ignored edge");
    // Second rising edge on input 1: width from successive captures
    u_pins.flip(4'h2);
    u_pins.flip(4'h2);
    t0 = $time;
    wt(1, 10, "second capture pulse");
    rd(`FRT_OFF_CCR1); c2 = v;
    chk(c2 - c > 16'h0000 && c2 - c < 16'h0020, 1, "width by difference");
  endtask

  task t_wrap;
    wt(4, 70000, "wrap pulse");
    nw = 1; // Bench's own overflow count for channel 1
    rd(`FRT_OFF_CNT);
    rd(`FRT_OFF_CNT); chk(v < 16'h0008, 1, "wrapped to zero");
    rd(`FRT_OFF_OPT); chk(v, 16'h0061, "overflow flag set");
    wr(`FRT_OFF_OPT, 16'h0061);
    rd(`FRT_OFF_OPT); chk(v, 16'h0061, "flag kept by a one");
    wr(`FRT_OFF_OPT, 16'h0060);
    rd(`FRT_OFF_OPT); chk(v, 16'h0060, "flag cleared");
    // Width across a wrap: N times 10000H plus the capture difference
    u_pins.flip(4'h2);
    u_pins.flip(4'h2);
    t1 = $time;
    wt(1, 10, "capture after wrap");
    rd(`FRT_OFF_CCR1);
    chk(32'h00010000 * nw + v - c2 == (t1 - t0) / 10, 1, "long width");
  endtask

  task end_of_test;
    $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Watchdog: the wrap wait alone takes about 66k cycles
  initial begin
    #1000000;
    mismatches++;
    end_of_test;
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    req = '0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_compare;
    t_capture;
    t_wrap;
    end_of_test;
  end
endmodule // tb_top
